// [rfd_defines.svh]
// Constants for the register file and data-space map block
`ifndef RFD_DEFINES_SVH
`define RFD_DEFINES_SVH

// Register file
`define RFD_NREG        32
`define RFD_IMM_BASE    5'h10
`define RFD_X_LO        5'h1a
`define RFD_Y_LO        5'h1c
`define RFD_Z_LO        5'h1e

// Data-space map
`define RFD_IO_BASE     16'h0020
`define RFD_SRAM_BASE   16'h0060
`define RFD_SRAM_END    16'h0260
`define RFD_SRAM_DEPTH  512
`define RFD_SRAM_AW     9
`define RFD_UNMAP_RD    8'h00

// Internal I/O locations
`define RFD_IO_SPL      6'h3d
`define RFD_IO_SPH      6'h3e
`define RFD_IO_SREG     6'h3f
`define RFD_GIE_BIT     7

// Program side
`define RFD_PC_W        12
`define RFD_RST_VEC     12'h000
`define RFD_CNST_BYTE   0
`define RFD_STK_W       10
`define RFD_STK_RST     10'h000
`define RFD_NIRQ        8

`endif

// [rfd_pkg.sv]
// Types shared by the register file and data-space map block
package rfd_pkg;

   // Data-space addressing modes
   typedef enum logic [2:0] {
      M_DIRECT  = 3'h0,
      M_DISP    = 3'h1,
      M_IND     = 3'h2,
      M_PREDEC  = 3'h3,
      M_POSTINC = 3'h4,
      M_IO      = 3'h5
   } rfd_mode_t;

   // Pointer pair select
   typedef enum logic [1:0] {
      P_X = 2'h0,
      P_Y = 2'h1,
      P_Z = 2'h2
   } rfd_ptr_t;

   // Decoded target of a data-space address
   typedef enum logic [1:0] {
      K_NONE = 2'h0,
      K_REG  = 2'h1,
      K_IO   = 2'h2,
      K_SRAM = 2'h3
   } rfd_kind_t;

   // Branch target source
   typedef enum logic {
      B_REL = 1'h0,
      B_IND = 1'h1
   } rfd_br_t;

   // Flow control states, one-hot
   typedef enum logic [2:0] {
      ST_RUN     = 3'h1,
      ST_PUSH_LO = 3'h2,
      ST_PUSH_HI = 3'h4
   } rfd_state_t;

endpackage

// [rfd_regfile.sv]
// Thirty-two working registers with three reads and prioritised writes
`timescale 1ns/1ps
`include "rfd_defines.svh"

module rfd_regfile import rfd_pkg::*;
(
   // Clock, reset and enable
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Read ports
   input  wire logic [4:0]  rd_a_sel,
   input  wire logic [4:0]  rd_b_sel,
   input  wire logic [4:0]  rd_c_sel,
   output logic      [7:0]  rd_a,
   output logic      [7:0]  rd_b,
   output logic      [7:0]  rd_c,
   // Pointer pair views
   output logic      [15:0] ptr_x,
   output logic      [15:0] ptr_y,
   output logic      [15:0] ptr_z,
   // Write ports, highest precedence first
   input  wire logic        res_we,
   input  wire logic [4:0]  res_sel,
   input  wire logic [7:0]  res_data,
   input  wire logic        dsp_we,
   input  wire logic [4:0]  dsp_sel,
   input  wire logic [7:0]  dsp_data,
   input  wire logic        ptr_we,
   input  wire logic [4:0]  ptr_lo_sel,
   input  wire logic [15:0] ptr_val
);

   logic [7:0] regs [`RFD_NREG];

   // One storage byte per register, fixed write precedence
   generate
      for (genvar i = 0; i < `RFD_NREG; i++)
      begin : g_reg
         localparam logic [4:0] IDX = 5'(i);
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               regs[i] <= 8'h00;
            else if (ce)
            begin
               if (res_we && res_sel == IDX)
                  regs[i] <= res_data;
               else if (dsp_we && dsp_sel == IDX)
                  regs[i] <= dsp_data;
               else if (ptr_we && ptr_lo_sel == IDX)
                  regs[i] <= ptr_val[7:0];
               else if (ptr_we && {ptr_lo_sel[4:1], 1'b1} == IDX)
                  regs[i] <= ptr_val[15:8];
            end
         end
      end
   endgenerate

   // Reads and pointer views
   assign rd_a  = regs[rd_a_sel];
   assign rd_b  = regs[rd_b_sel];
   assign rd_c  = regs[rd_c_sel];
   assign ptr_x = {regs[`RFD_X_LO + 5'h01], regs[`RFD_X_LO]};
   assign ptr_y = {regs[`RFD_Y_LO + 5'h01], regs[`RFD_Y_LO]};
   assign ptr_z = {regs[`RFD_Z_LO + 5'h01], regs[`RFD_Z_LO]};

endmodule // rfd_regfile

// [rfd_sram.sv]
// Internal data SRAM with registered read
`timescale 1ns/1ps
`include "rfd_defines.svh"

module rfd_sram
(
   // Clock and enable
   input  wire logic                    mclk,
   input  wire logic                    ce,
   // Access port
   input  wire logic                    en,
   input  wire logic                    we,
   input  wire logic [`RFD_SRAM_AW-1:0] addr,
   input  wire logic [7:0]              wdata,
   output logic      [7:0]              rdata
);

   logic [7:0] mem [`RFD_SRAM_DEPTH];

   // Write first-cycle, read data ready on the next cycle
   always_ff @(posedge mclk)
   begin
      if (ce && en)
      begin
         if (we)
            mem[addr] <= wdata;
         rdata <= mem[addr];
      end
   end

endmodule // rfd_sram

// [rfd_core.sv]
// Register file, data-space decode, fetch pipeline, stack and vectors
//
// Functional notes
// - Thirty-two byte registers; two operands read, one result written per cycle.
// - Registers 26 to 31 also read as three 16-bit pointer pairs.
// - The third pointer pair addresses constant reads from program memory.
// - Data addresses 0x00 to 0x1F reach the working registers.
// - Sixty-four I/O locations, direct or at data addresses 0x20 to 0x5F.
// - Two-stage pipeline prefetches next word while current one executes.
// - Program memory is 16-bit words; instructions span one or two words.
// - Program counter width matches the program word count.
// - Calls and interrupt acceptance push the return address onto SRAM stack.
// - Stack pointer is 10 bits, read and written through I/O space.
// - Per-interrupt vectors, global enable gate, lowest vector wins.
// - Immediate-class operations only target registers 16 to 31.
// - First 96 addresses are registers plus I/O, then internal SRAM.
// - Direct addressing reaches every data-space location.
// - Displacement mode adds unsigned 0 to 63 to the pointer.
// - Pre-decrement and post-increment write the pointer back.
// - Two-register operations read source and target, result to target.
// - I/O direct takes a 6-bit location plus a register number.
// - Operands come from register pairs, register and constant, or one register.
// - Relative jumps and calls reach the whole program space.
// - Pre-decrement uses decremented address; post-increment uses old one.
// - Constant reads: pointer bits above 0 pick word, bit 0 picks byte.
// - Direct addressing takes a 16-bit address from the second word.
`timescale 1ns/1ps
`include "rfd_defines.svh"

module rfd_core import rfd_pkg::*;
(
   // Clock, reset and enable
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   // Operand reads
   input  wire logic [4:0]           src_sel,
   input  wire logic [4:0]           dst_sel,
   input  wire logic                 imm_class,
   output logic      [7:0]           opnd_src_r,
   output logic      [7:0]           opnd_dst_r,
   // Result write-back
   input  wire logic                 res_we,
   input  wire logic [4:0]           res_sel,
   input  wire logic                 res_imm,
   input  wire logic [7:0]           res_data,
   // Data-space access
   input  wire logic                 dacc_req,
   input  wire logic                 dacc_we,
   input  wire rfd_mode_t            dacc_mode,
   input  wire rfd_ptr_t             dacc_ptr,
   input  wire logic [5:0]           dacc_disp,
   input  wire logic [15:0]          dacc_addr,
   input  wire logic [7:0]           dacc_wdata,
   output logic      [7:0]           dacc_rdata_r,
   output logic                      dacc_valid_r,
   // I/O peripherals
   input  wire logic [7:0]           io_rdata,
   input  wire logic [6:0]           alu_flags,
   output logic                      io_sel_r,
   output logic                      io_we_r,
   output logic      [5:0]           io_loc_r,
   output logic      [7:0]           io_wdata_r,
   // Program memory fetch
   input  wire logic [15:0]          pmem_data,
   output logic      [`RFD_PC_W-1:0] pmem_addr_r,
   output logic      [15:0]          ir_r,
   output logic                      ir_valid_r,
   // Constant table read
   input  wire logic                 cnst_req,
   output logic      [`RFD_PC_W-1:0] cnst_addr_r,
   output logic                      cnst_hi_r,
   output logic                      cnst_valid_r,
   // Flow control
   input  wire logic                 br_req,
   input  wire rfd_br_t              br_kind,
   input  wire logic                 br_call,
   input  wire logic [`RFD_PC_W-1:0] br_off,
   output logic                      busy_r,
   // Interrupts and stack
   input  wire logic [`RFD_NIRQ-1:0] irq_pend,
   output logic      [`RFD_NIRQ-1:0] irq_ack_r,
   output logic                      gie_r,
   output logic      [`RFD_STK_W-1:0] stack_pointer_r
);

   logic [7:0]             rd_a;
   logic [7:0]             rd_b;
   logic [7:0]             rd_c;
   logic [15:0]            ptr_x;
   logic [15:0]            ptr_y;
   logic [15:0]            ptr_z;
   logic [4:0]             dst_idx;
   logic [4:0]             res_idx;
   logic [15:0]            ptr_val;
   logic [4:0]             ptr_lo;
   logic [15:0]            ptr_new;
   logic                   ptr_wb;
   logic [15:0]            ea;
   rfd_kind_t              kind;
   logic [15:0]            io_off;
   logic [15:0]            sram_off;
   logic [15:0]            stk_off;
   logic                   run;
   logic                   dacc_go;
   logic                   io_int;
   logic [7:0]             io_int_val;
   logic                   sram_en;
   logic                   sram_we;
   logic [`RFD_SRAM_AW-1:0] sram_addr;
   logic [7:0]             sram_wdata;
   logic [7:0]             sram_rdata;
   logic [`RFD_NIRQ-1:0]   irq_lower;
   logic [`RFD_NIRQ-1:0]   irq_first;
   logic [`RFD_PC_W-1:0]   irq_vec;
   logic                   irq_take;
   logic [`RFD_PC_W-1:0]   br_tgt;
   logic [`RFD_PC_W-1:0]   ret_r;
   rfd_state_t             state_r;
   rfd_state_t             state_nxt;
   logic                   s1_valid_r;
   rfd_kind_t              s1_kind_r;
   logic [7:0]             s1_val_r;
   logic                   s1_int_r;

   // Immediate-class operations are folded onto the upper half
   assign dst_idx = imm_class ? (`RFD_IMM_BASE | {1'b0, dst_sel[3:0]}) : dst_sel;
   assign res_idx = res_imm ? (`RFD_IMM_BASE | {1'b0, res_sel[3:0]}) : res_sel;

   assign run     = (state_r == ST_RUN);
   assign dacc_go = run && dacc_req;

   // Working registers
   rfd_regfile u_regs
   (
      .mclk       (mclk),
      .rst        (rst),
      .ce         (ce),
      .rd_a_sel   (src_sel),
      .rd_b_sel   (dst_idx),
      .rd_c_sel   (ea[4:0]),
      .rd_a       (rd_a),
      .rd_b       (rd_b),
      .rd_c       (rd_c),
      .ptr_x      (ptr_x),
      .ptr_y      (ptr_y),
      .ptr_z      (ptr_z),
      .res_we     (res_we),
      .res_sel    (res_idx),
      .res_data   (res_data),
      .dsp_we     (dacc_go && dacc_we && kind == K_REG),
      .dsp_sel    (ea[4:0]),
      .dsp_data   (dacc_wdata),
      .ptr_we     (dacc_go && ptr_wb),
      .ptr_lo_sel (ptr_lo),
      .ptr_val    (ptr_new)
   );

   // Operands latched for the ALU, both source and target read
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         opnd_src_r <= 8'h00;
         opnd_dst_r <= 8'h00;
      end
      else if (ce)
      begin
         opnd_src_r <= rd_a;
         opnd_dst_r <= rd_b;
      end
   end

   // Pointer select and effective address per mode
   always_comb
   begin
      case (dacc_ptr)
         P_X:     begin ptr_val = ptr_x; ptr_lo = `RFD_X_LO; end
         P_Y:     begin ptr_val = ptr_y; ptr_lo = `RFD_Y_LO; end
         P_Z:     begin ptr_val = ptr_z; ptr_lo = `RFD_Z_LO; end
         default: begin ptr_val = ptr_x; ptr_lo = `RFD_X_LO; end
      endcase
      ptr_new = ptr_val;
      ptr_wb  = 1'b0;
      case (dacc_mode)
         M_DIRECT:  ea = dacc_addr;
         M_DISP:    ea = ptr_val + {10'h000, dacc_disp};
         M_IND:     ea = ptr_val;
         M_PREDEC:
         begin
            ptr_new = ptr_val - 16'h0001;
            ptr_wb  = 1'b1;
            ea      = ptr_new;
         end
         M_POSTINC:
         begin
            ptr_new = ptr_val + 16'h0001;
            ptr_wb  = 1'b1;
            ea      = ptr_val;
         end
         M_IO:      ea = `RFD_IO_BASE + {10'h000, dacc_disp};
         default:   ea = dacc_addr;
      endcase
   end

   // Data-space decode
   always_comb
   begin
      if (ea < `RFD_IO_BASE)
         kind = K_REG;
      else if (ea < `RFD_SRAM_BASE)
         kind = K_IO;
      else if (ea < `RFD_SRAM_END)
         kind = K_SRAM;
      else
         kind = K_NONE;
   end

   assign io_off   = ea - `RFD_IO_BASE;
   assign sram_off = ea - `RFD_SRAM_BASE;
   assign stk_off  = {6'h00, stack_pointer_r} - `RFD_SRAM_BASE;

   // Locations held inside this block
   always_comb
   begin
      io_int     = 1'b1;
      io_int_val = 8'h00;
      case (io_off[5:0])
         `RFD_IO_SPL:  io_int_val = stack_pointer_r[7:0];
         `RFD_IO_SPH:  io_int_val = 8'(stack_pointer_r[`RFD_STK_W-1:8]);
         `RFD_IO_SREG: io_int_val = {gie_r, alu_flags};
         default:      io_int = 1'b0;
      endcase
   end

   // SRAM port shared by data accesses and return-address pushes
   always_comb
   begin
      sram_en    = dacc_go && kind == K_SRAM;
      sram_we    = dacc_we;
      sram_addr  = sram_off[`RFD_SRAM_AW-1:0];
      sram_wdata = dacc_wdata;
      if (!run)
      begin
         sram_en    = 1'b1;
         sram_we    = 1'b1;
         sram_addr  = stk_off[`RFD_SRAM_AW-1:0];
         sram_wdata = (state_r == ST_PUSH_LO) ? ret_r[7:0] : 8'(ret_r[`RFD_PC_W-1:8]);
      end
   end

   rfd_sram u_sram
   (
      .mclk  (mclk),
      .ce    (ce),
      .en    (sram_en),
      .we    (sram_we),
      .addr  (sram_addr),
      .wdata (sram_wdata),
      .rdata (sram_rdata)
   );

   // Access stage one: capture kind and early read values
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s1_valid_r <= 1'b0;
         s1_kind_r  <= K_NONE;
         s1_val_r   <= 8'h00;
         s1_int_r   <= 1'b0;
      end
      else if (ce)
      begin
         s1_valid_r <= dacc_go && !dacc_we;
         s1_kind_r  <= kind;
         s1_val_r   <= (kind == K_REG) ? rd_c : io_int_val;
         s1_int_r   <= io_int;
      end
   end

   // External I/O strobes, one cycle after the request
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         io_sel_r   <= 1'b0;
         io_we_r    <= 1'b0;
         io_loc_r   <= 6'h00;
         io_wdata_r <= 8'h00;
      end
      else if (ce)
      begin
         io_sel_r   <= dacc_go && kind == K_IO;
         io_we_r    <= dacc_go && kind == K_IO && dacc_we;
         io_loc_r   <= io_off[5:0];
         io_wdata_r <= dacc_wdata;
      end
   end

   // Access stage two: read answer
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dacc_valid_r <= 1'b0;
         dacc_rdata_r <= 8'h00;
      end
      else if (ce)
      begin
         dacc_valid_r <= s1_valid_r;
         case (s1_kind_r)
            K_REG:   dacc_rdata_r <= s1_val_r;
            K_IO:    dacc_rdata_r <= s1_int_r ? s1_val_r : io_rdata;
            K_SRAM:  dacc_rdata_r <= sram_rdata;
            default: dacc_rdata_r <= `RFD_UNMAP_RD;
         endcase
      end
   end

   // Stack pointer, pushes take priority over I/O writes
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         stack_pointer_r <= `RFD_STK_RST;
      else if (ce)
      begin
         if (!run)
            stack_pointer_r <= stack_pointer_r - 10'h001;
         else if (dacc_go && dacc_we && kind == K_IO && io_off[5:0] == `RFD_IO_SPL)
            stack_pointer_r[7:0] <= dacc_wdata;
         else if (dacc_go && dacc_we && kind == K_IO && io_off[5:0] == `RFD_IO_SPH)
            stack_pointer_r[`RFD_STK_W-1:8] <= dacc_wdata[`RFD_STK_W-9:0];
      end
   end

   // Lowest pending line wins
   generate
      for (genvar i = 0; i < `RFD_NIRQ; i++)
      begin : g_irq
         if (i == 0)
         begin : g_first
            assign irq_lower[i] = 1'b0;
         end
         else
         begin : g_rest
            assign irq_lower[i] = irq_lower[i-1] | irq_pend[i-1];
         end
         assign irq_first[i] = irq_pend[i] & ~irq_lower[i];
      end
   endgenerate

   // Vector word: the reset vector sits below all interrupt vectors
   always_comb
   begin
      irq_vec = `RFD_RST_VEC;
      for (int k = 0; k < `RFD_NIRQ; k++)
      begin
         if (irq_first[k])
            irq_vec = `RFD_RST_VEC + `RFD_PC_W'(k + 1);
      end
   end

   assign irq_take = run && gie_r && (|irq_pend) && !br_req && !dacc_req;
   assign br_tgt   = (br_kind == B_IND) ? ptr_z[`RFD_PC_W-1:0]
                                        : pmem_addr_r + br_off;

   // Global enable: cleared on acceptance, written through status location
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         gie_r <= 1'b0;
      else if (ce)
      begin
         if (irq_take)
            gie_r <= 1'b0;
         else if (dacc_go && dacc_we && kind == K_IO && io_off[5:0] == `RFD_IO_SREG)
            gie_r <= dacc_wdata[`RFD_GIE_BIT];
      end
   end

   // Next flow state
   always_comb
   begin
      case (state_r)
         ST_RUN:     state_nxt = ((br_req && br_call) || irq_take) ? ST_PUSH_LO : ST_RUN;
         ST_PUSH_LO: state_nxt = ST_PUSH_HI;
         ST_PUSH_HI: state_nxt = ST_RUN;
         default:    state_nxt = ST_RUN;
      endcase
   end

   // Flow state, busy flag, acknowledge and return address
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_r   <= ST_RUN;
         busy_r    <= 1'b0;
         irq_ack_r <= '0;
         ret_r     <= `RFD_RST_VEC;
      end
      else if (ce)
      begin
         state_r   <= state_nxt;
         busy_r    <= (state_nxt != ST_RUN);
         irq_ack_r <= irq_take ? irq_first : '0;
         if (run)
            ret_r <= pmem_addr_r;
      end
   end

   // Fetch pipeline: next word fetched while the held one executes
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pmem_addr_r <= `RFD_RST_VEC;
         ir_r        <= 16'h0000;
         ir_valid_r  <= 1'b0;
      end
      else if (ce)
      begin
         if (run && br_req)
         begin
            pmem_addr_r <= br_tgt;
            ir_valid_r  <= 1'b0;
         end
         else if (irq_take)
         begin
            pmem_addr_r <= irq_vec;
            ir_valid_r  <= 1'b0;
         end
         else if (run)
         begin
            ir_r        <= pmem_data;
            ir_valid_r  <= 1'b1;
            pmem_addr_r <= pmem_addr_r + `RFD_PC_W'(1);
         end
         else
            ir_valid_r  <= 1'b0;
      end
   end

   // Constant table address from the third pointer pair
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cnst_addr_r  <= `RFD_RST_VEC;
         cnst_hi_r    <= 1'b0;
         cnst_valid_r <= 1'b0;
      end
      else if (ce)
      begin
         cnst_addr_r  <= ptr_z[`RFD_PC_W:1];
         cnst_hi_r    <= ptr_z[`RFD_CNST_BYTE];
         cnst_valid_r <= cnst_req;
      end
   end

endmodule // rfd_core

// [rfd_core_sva.sv]
// Assertion checker for the data-space core, bound to its ports
`timescale 1ns/1ps
`include "rfd_defines.svh"
module rfd_core_sva import rfd_pkg::*;
(
   // Clock and reset
   input wire logic                 mclk, rst,
   // Watched handshakes
   input wire logic                 dacc_req, dacc_we, dacc_valid_r, io_sel_r, busy_r,
   input wire logic                 br_req, br_call, ir_valid_r, cnst_req, cnst_valid_r, gie_r,
   // Watched values
   input wire rfd_mode_t            dacc_mode,
   input wire logic [5:0]           dacc_disp, io_loc_r,
   input wire logic [15:0]          dacc_addr,
   input wire logic [7:0]           irq_pend, irq_ack_r,
   input wire logic [`RFD_PC_W-1:0] pmem_addr_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Accepted access, and its direct-mode form
   wire tk = dacc_req && !busy_r;
   wire dr = tk && dacc_mode == M_DIRECT;
   sequence s_push; busy_r [*2] ##1 !busy_r; endsequence
   sequence s_take; gie_r && |irq_pend && !busy_r && !br_req && !dacc_req; endsequence
   a_read_valid: assert property (tk && !dacc_we |-> ##2 dacc_valid_r)
      else $error("read answer missing");
   a_io_loc: assert property (tk && dacc_mode == M_IO |=> io_sel_r && io_loc_r == $past(dacc_disp))
      else $error("io location wrong");
   a_io_window: assert property (dr && dacc_addr inside {[16'h0020:16'h005f]}
      |=> io_sel_r && io_loc_r == $past(dacc_addr[5:0]) - 6'h20) else $error("io window wrong");
   a_reg_no_io: assert property (dr && dacc_addr < 16'h0020 |=> !io_sel_r)
      else $error("register access hit io");
   a_sram_no_io: assert property (dr && dacc_addr >= 16'h0060 |=> !io_sel_r)
      else $error("sram access hit io");
   a_call_push: assert property (br_req && br_call && !busy_r |=> s_push)
      else $error("call push length wrong");
   a_fetch_flush: assert property (br_req && !busy_r |=> !ir_valid_r)
      else $error("stale word after redirect");
   a_cnst_valid: assert property (cnst_req |=> cnst_valid_r)
      else $error("constant read gave no valid");
   a_irq_pick: assert property (s_take |=> !gie_r
      && irq_ack_r == ($past(irq_pend) & ~($past(irq_pend) - 8'h01))) else $error("irq pick wrong");
   a_irq_vector: assert property (|irq_ack_r |-> pmem_addr_r == $countones(irq_ack_r - 8'h01) + 1)
      else $error("irq vector wrong");
endmodule // rfd_core_sva
bind rfd_core rfd_core_sva u_sva (.mclk, .rst, .dacc_req, .dacc_we, .dacc_valid_r, .io_sel_r,
   .busy_r, .br_req, .br_call, .ir_valid_r, .cnst_req, .cnst_valid_r, .gie_r, .dacc_mode,
   .dacc_disp, .io_loc_r, .dacc_addr, .irq_pend, .irq_ack_r, .pmem_addr_r);

// [rfd_far_model.sv]
// Far-side model: program memory and one peripheral read port
`timescale 1ns/1ps
`include "rfd_defines.svh"
module rfd_far_model
(
   // Fetch side
   input  wire logic [`RFD_PC_W-1:0] pmem_addr_r,
   output logic      [15:0]          pmem_data,
   // Peripheral side
   input  wire logic                 io_sel_r,
   input  wire logic [5:0]           io_loc_r,
   output logic      [7:0]           io_rdata
);
   // Word follows its address, so a wrong fetch shows
   assign pmem_data = {4'h5, pmem_addr_r};
   // Answers only while selected, inverse pattern otherwise
   assign io_rdata = io_sel_r ? {2'h2, io_loc_r} : ~{2'h2, io_loc_r};
endmodule // rfd_far_model

// [rfd_core_tb.sv]
// Self-checking bench for the data-space core
`timescale 1ns/1ps
`include "rfd_defines.svh"
module rfd_core_tb import rfd_pkg::*;;
   logic mclk, rst, ce, imm_class, res_we, res_imm, dacc_req, dacc_we, cnst_req, br_req, br_call;
   logic dacc_valid_r, io_sel_r, cnst_hi_r, cnst_valid_r;
   logic [4:0] src_sel, dst_sel, res_sel;
   logic [5:0] dacc_disp, io_loc_r;
   logic [6:0] alu_flags;
   logic [7:0] res_data, dacc_wdata, dacc_rdata_r, io_rdata, irq_pend, irq_ack_r, v;
   logic [11:0] br_off, pmem_addr_r, cnst_addr_r;
   logic [15:0] dacc_addr, pmem_data;
   rfd_mode_t dacc_mode;
   rfd_ptr_t dacc_ptr;
   rfd_br_t br_kind;
   logic [7:0] q[$];
   int errors, cmp_count, n;
   rfd_core dut_u (.*, .opnd_src_r(), .opnd_dst_r(), .io_we_r(), .io_wdata_r(), .ir_r(),
      .ir_valid_r(), .busy_r(), .gie_r(),
      .stack_pointer_r());
   rfd_far_model far_u (.pmem_addr_r, .pmem_data, .io_sel_r, .io_loc_r, .io_rdata);
   // Clock
   initial
   begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Data access; for a read, d is the expected answer
   task automatic acc(input logic w, input rfd_mode_t m, input rfd_ptr_t p, input logic [15:0] a,
                      input logic [7:0] d);
      if (!w)
         q.push_back(d);
      @(posedge mclk);
      dacc_mode <= m;
      dacc_ptr <= p;
      {dacc_req, dacc_we, dacc_addr, dacc_disp, dacc_wdata} <= {1'h1, w, a, a[5:0], d};
      @(posedge mclk);
      dacc_req <= 1'h0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic rw(input logic im, input logic [4:0] s, input logic [7:0] d);
      @(posedge mclk);
      {res_we, res_imm, res_sel, res_data} <= {1'h1, im, s, d};
      @(posedge mclk);
      res_we <= 1'h0;
   endtask
   // Read answers against the oldest note
   always @(posedge mclk)
      if (dacc_valid_r === 1'h1)
         chk("read data", dacc_rdata_r, (q.size() > 0) ? q.pop_front() : ~dacc_rdata_r);
   // Random operand selects
   always @(posedge mclk)
      {src_sel, dst_sel, imm_class} <= 11'($urandom);
   // Watchdog
   initial
   begin
      repeat (2000) @(posedge mclk);
      errors++;
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      void'($urandom(48));
      {rst, ce, res_we, res_imm, res_sel, res_data, dacc_req, dacc_we, dacc_addr} = {2'h3, 33'h0};
      {dacc_disp, dacc_wdata, cnst_req, br_req, br_call, br_off, irq_pend} = '0;
      alu_flags = 7'h2a;
      dacc_mode = M_DIRECT;
      dacc_ptr = P_X;
      br_kind = B_REL;
      repeat (6) @(posedge mclk);
      rst <= 1'h0;
      acc(0, M_DIRECT, P_X, 16'h0005, 8'h00);
      acc(0, M_DIRECT, P_X, 16'h005d, 8'h00);
      repeat (4)
      begin
         n = $urandom_range(25, 0);
         v = 8'($urandom);
         rw(0, n[4:0], v);
         acc(0, M_DIRECT, P_X, {11'h0, n[4:0]}, v);
      end
      rw(1, 5'h03, 8'h3c);
      acc(0, M_DIRECT, P_X, 16'h0013, 8'h3c);
      acc(1, M_DIRECT, P_X, 16'h0060, 8'ha5);
      acc(1, M_DIRECT, P_X, 16'h025f, 8'h5a);
      acc(1, M_DIRECT, P_X, 16'h0260, 8'hff);
      acc(0, M_DIRECT, P_X, 16'h0060, 8'ha5);
      acc(0, M_DIRECT, P_X, 16'h025f, 8'h5a);
      acc(0, M_DIRECT, P_X, 16'h0260, 8'h00);
      $display("map test done");
      rw(0, 5'h1a, 8'h00);
      rw(0, 5'h1b, 8'h01);
      acc(1, M_POSTINC, P_X, 16'h0000, 8'hc3);
      acc(0, M_DIRECT, P_X, 16'h001a, 8'h01);
      acc(0, M_PREDEC, P_X, 16'h0000, 8'hc3);
      acc(0, M_DIRECT, P_X, 16'h001a, 8'h00);
      fork
         rw(0, 5'h1a, 8'h40);
         acc(1, M_POSTINC, P_X, 16'h0000, 8'h11);
      join
      acc(0, M_DIRECT, P_X, 16'h001a, 8'h40);
      rw(0, 5'h1c, 8'h00);
      rw(0, 5'h1d, 8'h01);
      acc(1, M_DIRECT, P_X, 16'h013f, 8'h77);
      acc(0, M_DISP, P_Y, 16'h003f, 8'h77);
      rw(0, 5'h1e, 8'h35);
      rw(0, 5'h1f, 8'h02);
      @(posedge mclk);
      cnst_req <= 1'h1;
      @(posedge mclk);
      cnst_req <= 1'h0;
      @(posedge mclk);
      chk("cnst word", cnst_addr_r[7:0], 8'h1a);
      chk("cnst byte", {cnst_valid_r, cnst_hi_r, 2'h0, cnst_addr_r[11:8]}, 8'hc1);
      $display("pointer test done");
      acc(0, M_IO, P_X, 16'h0010, 8'h90);
      acc(0, M_DIRECT, P_X, 16'h0030, 8'h90);
      acc(1, M_IO, P_X, 16'h003d, 8'h5f);
      acc(1, M_IO, P_X, 16'h003e, 8'h02);
      acc(0, M_DIRECT, P_X, 16'h005e, 8'h02);
      @(posedge mclk);
      {br_req, br_call, br_off} <= {2'h3, 12'h010};
      @(posedge mclk);
      br_req <= 1'h0;
      repeat (4) @(posedge mclk);
      acc(0, M_DIRECT, P_X, 16'h005d, 8'h5d);
      $display("stack test done");
      acc(1, M_DIRECT, P_X, 16'h005f, 8'h80);
      acc(0, M_DIRECT, P_X, 16'h005f, 8'haa);
      @(posedge mclk);
      irq_pend <= 8'h0a;
      n = 0;
      while (irq_ack_r !== 8'h02 && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
      chk("irq ack", irq_ack_r, 8'h02);
      irq_pend <= 8'h00;
      repeat (3) @(posedge mclk);
      acc(0, M_DIRECT, P_X, 16'h005d, 8'h5b);
      acc(0, M_DIRECT, P_X, 16'h005f, 8'h2a);
      $display("interrupt test done");
      tally_and_finish();
   end
endmodule // rfd_core_tb
